// ---- bench/apb_host.sv ----
// partner model: bus master standing in for software
`timescale 1ns/1ns
`default_nettype none
module apb_host (
  input  wire logic        pclk,    // clock
  output var  logic        psel,    // select
  output var  logic        penable, // enable
  output var  logic        pwrite,  // direction
  output var  logic [11:0] paddr,   // address
  output var  logic [31:0] pwdata,  // write data
  input  wire logic [31:0] prdata,  // read data
  input  wire logic        pready,  // ready
  input  wire logic        pslverr  // error
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // r[1] flags a wait that ran out
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    q = prdata;
    r = {pready !== 1'h1, pslverr};
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
endmodule : apb_host
`default_nettype wire

// ---- bench/minmax_fuzzy_move_exec_chk.sv ----
// checker: bus timing and busy behaviour at the unit's ports
`timescale 1ns/1ns
`default_nettype none
module minmax_fuzzy_move_exec_chk
  import minmax_pkg::*;
(
  input wire logic        pclk,    // clock
  input wire logic        presetn, // reset, low
  input wire logic        psel,    // select
  input wire logic        penable, // enable
  input wire logic        pwrite,  // direction
  input wire logic [11:0] paddr,   // address
  input wire logic [31:0] pwdata,  // write data
  input wire logic [31:0] prdata,  // read data
  input wire logic        pready,  // ready
  input wire logic        pslverr, // error
  input wire logic        busy     // running
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence start_s;
    psel && penable && pready && pwrite && paddr == off_instr && !busy;
  endsequence
  ready_next_a: assert property (setup_s |=> pready && psel && penable)
    else $error("ready missing after setup");
  ready_only_a: assert property (pready |-> $past(psel && !penable) && psel && penable)
    else $error("ready outside access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_unmapped_a: assert property (pready && paddr > off_opnd |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  no_err_a: assert property (pready && paddr <= off_opnd && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  busy_start_a: assert property (start_s |=> busy)
    else $error("busy did not rise");
  busy_end_a: assert property ($rose(busy) |-> ##[1:40] !busy)
    else $error("instruction did not end");
  busy_quiet_a: assert property (!busy && !(psel && penable && pwrite && paddr == off_instr) |=> !busy)
    else $error("busy without start");
endmodule : minmax_fuzzy_move_exec_chk
bind minmax_fuzzy_move_exec minmax_fuzzy_move_exec_chk i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
`default_nettype wire

// ---- bench/tb_top.sv ----
// testbench: bus-driven scenarios against a behavioural model of the unit
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import minmax_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  ma, mc;
  logic [15:0] mx, my, w;
  byte unsigned mm[256];
  int          fail_count = 0;
  int          comparisons = 0;
  logic [31:0] trap[5] = '{32'h20006008, 32'h20046000, 32'h20046000, 32'h20026002, 32'h1003f003};
  logic [7:0]  crisp[5] = '{8'h58, 8'h60, 8'h24, 8'h10, 8'h00};
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  minmax_fuzzy_move_exec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy));
  apb_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic bus(logic wr, logic [11:0] a, logic [31:0] d, logic err);
    logic [1:0] r;
    i_host.xfer(wr, a, d, rd, r);
    if (r[1]) begin
      fail_count++;
      stop_test();
    end
    check("pslverr", 32'(r[0]), 32'(err));
  endtask : bus
  task automatic rdchk(string what, logic [11:0] a, logic [31:0] e);
    bus(1'h0, a, 32'h0, 1'h0);
    check(what, rd, e);
  endtask : rdchk
  task automatic load(logic [7:0] a, logic [15:0] x, logic [15:0] y, logic [15:0] op);
    bus(1'h1, off_acc_a, 32'(a), 1'h0);
    bus(1'h1, off_index_x, 32'(x), 1'h0);
    bus(1'h1, off_index_y, 32'(y), 1'h0);
    bus(1'h1, off_opnd, 32'(op), 1'h0);
    ma = a;
    mx = x;
    my = y;
  endtask : load
  task automatic run(logic [7:0] b0, logic [7:0] b1, logic [7:0] b2, logic ill);
    int n;
    bus(1'h1, off_instr, {b0, b1, b2, 8'h00}, 1'h0);
    n = 0;
    repeat (2) @(posedge pclk);
    while (busy !== 1'h0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n == 100) begin
      fail_count++;
      stop_test();
    end
    bus(1'h0, off_status, 32'h0, 1'h0);
    check("illegal", 32'(rd[st_illegal]), 32'(ill));
  endtask : run
  task automatic minmax(logic [7:0] op, logic [7:0] a, logic [7:0] ad, logic [3:0] off);
    logic [7:0] m, r;
    m = mm[ad];
    load(a, {8'h00, 8'(ad - off)}, my, 16'h0);
    run(prefix_byte, op, {4'h0, off}, 1'h0);
    r = a - m;
    mc[cc_n] = r[7];
    mc[cc_z] = (r == 8'h00);
    mc[cc_v] = (a[7] & ~m[7] & ~r[7]) | (~a[7] & m[7] & r[7]);
    mc[cc_c] = m > a;
    case (op)
      op_max_to_acc_a: ma = m > a ? m : a;
      op_min_to_acc_a: ma = m < a ? m : a;
      op_max_to_memory: mm[ad] = m > a ? m : a;
      default: mm[ad] = m < a ? m : a;
    endcase
    rdchk("acc_a", off_acc_a, 32'(ma));
    rdchk("cc_bits", off_cc, 32'(mc));
  endtask : minmax
  task automatic put(logic [7:0] ad, logic [7:0] v);
    load(ma, mx, {8'h00, ad}, {8'h00, v});
    run(prefix_byte, op_byte_lit_ptr, 8'h00, 1'h0);
    mm[ad] = v;
    rdchk("cc_bits", off_cc, 32'(mc));
  endtask : put
  function automatic int grade(int p1, int s1, int p2, int s2, int c);
    int l, t;
    if (c < p1 || c > p2) return 0;
    l = s1 == 0 ? 255 : (c - p1) * s1;
    t = s2 == 0 ? 255 : (p2 - c) * s2;
    if (t < l) l = t;
    return l > 255 ? 255 : l;
  endfunction : grade
  initial begin
    presetn = 1'h0;
    void'($urandom(22593));
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    {ma, mx, my, mc} = {8'h00, 16'h0, 16'h0, cc_reset};
    rdchk("cc_bits", off_cc, 32'(cc_reset));
    rdchk("index_y", off_index_y, 32'h0);
    bus(1'h0, 12'h020, 32'h0, 1'h1);
    check("unmapped", rd, 32'h0);
    mc = {4'hd, 4'($urandom)};
    bus(1'h1, off_cc, 32'(mc), 1'h0);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      w = 16'($urandom);
      put(w[7:0] & 8'h3f, w[15:8]);
      minmax(8'h18 + 8'(i % 2) + 8'(i % 4 / 2 * 4), i < 4 ? w[15:8] : 8'($urandom),
             w[7:0] & 8'h3f, 4'($urandom));
      minmax(op_min_to_acc_a, 8'hff, w[7:0] & 8'h3f, 4'h0);
    end
    $display("test minmax done");
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 4; k++) put(8'h40 + 8'(k), trap[i][31 - 8 * k -: 8]);
      if (i == 4) crisp[i] = 8'($urandom);
      load(crisp[i], 16'h0040, 16'h0080, 16'h0);
      run(op_membership, 8'h00, 8'h00, 1'h0);
      mm[8'h80] = 8'(grade(trap[i][31:24], trap[i][23:16], trap[i][15:8], trap[i][7:0], crisp[i]));
      rdchk("acc_a", off_acc_a, 32'(ma));
      rdchk("index_x", off_index_x, 32'(mx + x_step));
      rdchk("index_y", off_index_y, 32'(my + y_step));
      bus(1'h0, off_cc, 32'h0, 1'h0);
      mc = rd[7:0];
      minmax(op_min_to_acc_a, 8'hff, 8'h80, 4'h0);
    end
    $display("test membership done");
    load(ma, mx, 16'h0090, w);
    run(prefix_byte, op_word_lit_ptr, 8'h00, 1'h0);
    mm[8'h90] = w[15:8];
    mm[8'h91] = w[7:0];
    rdchk("cc_bits", off_cc, 32'(mc));
    minmax(op_min_to_acc_a, 8'hff, 8'h90, 4'h0);
    minmax(op_min_to_acc_a, 8'hff, 8'h91, 4'h0);
    load(ma, mx, 16'h00a0, 16'h0090);
    run(prefix_byte, op_byte_abs_ptr, 8'h00, 1'h0);
    mm[8'ha0] = mm[8'h90];
    rdchk("cc_bits", off_cc, 32'(mc));
    minmax(op_min_to_acc_a, 8'hff, 8'ha0, 4'h0);
    minmax(op_min_to_acc_a, 8'hff, 8'h90, 4'h0);
    load(ma, 16'h0090, 16'h00b0, 16'h00c0);
    run(prefix_byte, op_byte_ptr_abs, 8'h01, 1'h0);
    mm[8'hc0] = mm[8'h91];
    rdchk("cc_bits", off_cc, 32'(mc));
    minmax(op_min_to_acc_a, 8'hff, 8'hc0, 4'h0);
    load(ma, 16'h0090, 16'h00b0, 16'h0000);
    run(prefix_byte, op_word_ptr_ptr, 8'h00, 1'h0);
    mm[8'hb0] = mm[8'h90];
    mm[8'hb1] = mm[8'h91];
    rdchk("cc_bits", off_cc, 32'(mc));
    minmax(op_min_to_acc_a, 8'hff, 8'hb0, 4'h0);
    minmax(op_min_to_acc_a, 8'hff, 8'hb1, 4'h0);
    minmax(op_min_to_acc_a, 8'hff, 8'h91, 4'h0);
    $display("test moves done");
    run(prefix_byte, op_byte_lit_ptr, 8'he7, 1'h1);
    run(prefix_byte, op_min_to_acc_a, 8'he7, 1'h1);
    rdchk("acc_a", off_acc_a, 32'(ma));
    $display("test illegal done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire

// ---- hw/byte_mem.sv ----
// byte memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module byte_mem
  import minmax_pkg::*;
(
  input wire logic pclk,   // clock
  mem_if.slave     bus     // access port
);
  logic [7:0] store [mem_depth];

  always_ff @(posedge pclk) begin
    if (bus.wr) begin
      store[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge pclk) begin
    bus.rdata <= store[bus.addr];
  end
endmodule : byte_mem
`default_nettype wire

// ---- hw/grade_calc.sv ----
// trapezoid membership grade from crisp input and four descriptor bytes
`timescale 1ns/1ns
`default_nettype none
module grade_calc
  import minmax_pkg::*;
(
  input  wire logic [7:0] crisp,    // crisp input
  input  wire logic [7:0] point_1,  // leading edge start
  input  wire logic [7:0] slope_1,  // leading slope
  input  wire logic [7:0] point_2,  // trailing point
  input  wire logic [7:0] slope_2,  // trailing slope
  output      logic [7:0] grade     // membership grade
);
  logic [15:0] lead;
  logic [15:0] trail;
  logic [7:0]  lead_g;
  logic [7:0]  trail_g;

  always_comb begin
    lead  = 16'((crisp - point_1) * slope_1);
    trail = 16'((point_2 - crisp) * slope_2);
    // zero slope means a vertical edge at the point
    if (slope_1 == slope_infinite) begin
      lead_g = grade_full;
    end else begin
      lead_g = (lead[15:8] != 8'h00) ? grade_full : lead[7:0];
    end
    if (slope_2 == slope_infinite) begin
      trail_g = grade_full;
    end else begin
      trail_g = (trail[15:8] != 8'h00) ? grade_full : trail[7:0];
    end
    if (crisp < point_1 || crisp > point_2) begin
      grade = 8'h00;
    end else begin
      grade = (lead_g < trail_g) ? lead_g : trail_g;
    end
  end
endmodule : grade_calc
`default_nettype wire

// ---- hw/minmax_fuzzy_move_exec.sv ----
// execution unit: unsigned max/min, fuzzy membership grade and memory moves
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module minmax_fuzzy_move_exec
  import minmax_pkg::*;
(
  input  wire logic        pclk,     // clock
  input  wire logic        presetn,  // async reset, low
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb enable
  input  wire logic        pwrite,   // apb direction
  input  wire logic [11:0] paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output      logic [31:0] prdata,   // apb read data
  output      logic        pready,   // apb ready
  output      logic        pslverr,  // apb error
  output      logic        busy      // instruction running
);
  import minmax_pkg::*;

  typedef enum logic [3:0] {
    st_idle   = 4'b0000,
    st_addr   = 4'b0001,
    st_rd     = 4'b0011,
    st_rd_w   = 4'b0010,
    st_exec   = 4'b0110,
    st_wr     = 4'b0111,
    st_wr2    = 4'b0101,
    st_fin    = 4'b0100,
    st_rdx    = 4'b1100
  } state_e;

  mem_if mem ();
  byte_mem u_mem (.pclk(pclk), .bus(mem));

  state_e      state;
  logic [7:0]  acc_a;
  logic [15:0] index_x;
  logic [15:0] index_y;
  logic [7:0]  cc_bits;
  logic [31:0] instr;
  logic [15:0] opnd;       // extended address or immediate data
  logic        done;
  logic        illegal;
  logic        start;
  logic [7:0]  src_addr;
  logic [7:0]  dst_addr;
  logic [7:0]  data_lo;
  logic [7:0]  data_hi;
  logic [1:0]  cnt;
  logic [7:0]  desc [4];
  logic [7:0]  grade;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] xb;
  logic       is_mem_grade;
  logic       is_minmax;
  logic       is_move;
  logic       is_word;
  logic       src_lit;
  logic       src_ptr;
  logic       dst_ptr;
  logic       xb_ok;
  logic [7:0] diff;
  logic       borrow;
  logic       borrow_q;

  always_comb begin
    b0 = instr[instr_b0_lsb +: 8];
    b1 = instr[instr_b1_lsb +: 8];
    xb = instr[instr_b2_lsb +: 8];
    is_mem_grade = (b0 == op_membership);
    is_minmax = (b0 == prefix_byte) && (b1 == op_max_to_acc_a || b1 == op_min_to_acc_a ||
                b1 == op_max_to_memory || b1 == op_min_to_memory);
    is_move = (b0 == prefix_byte) && (b1 <= op_word_ptr_abs ||
              (b1 >= op_byte_lit_ptr && b1 <= op_byte_ptr_abs));
    is_word = (b1 <= op_word_ptr_abs);
    // first operand is the source
    case (b1[2:0])
      3'h0, 3'h3: src_lit = 1'b1;
      default:    src_lit = 1'b0;
    endcase
    src_ptr = (b1[2:0] == 3'h2) || (b1[2:0] == 3'h5);
    dst_ptr = (b1[2:0] <= 3'h2);
    // single postbyte form: 5-bit offset or short postbyte, no indirect
    xb_ok = !(xb[5] && xb[7:6] == 2'b11 && xb[2]);
    {borrow, diff} = {1'b0, acc_a} - {1'b0, mem.rdata};
  end

  // effective index address from postbyte 5-bit offset on the given base (x for the source and the min/max destination, y for the move destination)
  function automatic logic [7:0] ea_ptr(input logic [7:0] pb, input logic [15:0] base);
    logic [7:0] off;
    off = {{3{pb[4]}}, pb[4:0]};
    ea_ptr = 8'(base[7:0] + off);
  endfunction : ea_ptr

  assign start = psel && penable && pwrite && paddr == off_instr && state == st_idle;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= st_idle;
      cnt     <= 2'd0;
      data_lo <= 8'h00;
      data_hi <= 8'h00;
      src_addr <= 8'h00;
      dst_addr <= 8'h00;
      done    <= 1'b0;
      illegal <= 1'b0;
    end else begin
      case (state)
        st_idle: begin
          if (start) begin
            done    <= 1'b0;
            illegal <= 1'b0;
            state   <= st_addr;
          end
        end
        st_addr: begin
          cnt <= 2'd0;
          if (is_mem_grade) begin
            src_addr <= index_x[7:0];
            state    <= st_rdx;
          end else if (is_minmax && xb_ok) begin
            src_addr <= ea_ptr(xb, index_x);
            dst_addr <= ea_ptr(xb, index_x);
            state    <= st_rd;
          end else if (is_move && (!src_ptr || xb_ok) && (!dst_ptr || xb_ok)) begin
            src_addr <= src_ptr ? ea_ptr(xb, index_x) : opnd[7:0];
            dst_addr <= dst_ptr ? ea_ptr(xb, index_y) : opnd[7:0];
            data_hi  <= opnd[15:8];
            data_lo  <= opnd[7:0];
            state    <= src_lit ? st_wr : st_rd;
          end else begin
            illegal <= 1'b1;
            state   <= st_fin;
          end
        end
        st_rdx: begin
          src_addr <= 8'(src_addr + 8'd1);
          cnt      <= 2'(cnt + 2'd1);
          if (cnt != 2'd0) begin
            desc[cnt - 2'd1] <= mem.rdata;
          end
          if (cnt == 2'd3) begin
            state <= st_rd_w;
          end
        end
        st_rd_w: begin
          desc[3] <= mem.rdata;
          state   <= st_exec;
        end
        st_rd: begin
          state <= st_rd_w;
        end
        st_exec: begin
          if (is_move) begin
            if (is_word && cnt == 2'd0) begin
              data_hi  <= mem.rdata;
              src_addr <= 8'(src_addr + 8'd1);
              cnt      <= 2'd1;
              state    <= st_rd;
            end else begin
              data_lo <= mem.rdata;
              state   <= st_wr;
            end
          end else begin
            data_lo <= mem.rdata;
            state   <= st_wr;
          end
        end
        st_wr: begin
          state <= (is_move && is_word) ? st_wr2 : st_fin;
        end
        st_wr2: begin
          state <= st_fin;
        end
        st_fin: begin
          done  <= 1'b1;
          state <= st_idle;
        end
        default: state <= st_idle;
      endcase
    end
  end

  // ----------------------------------------
  // memory port
  // ----------------------------------------
  grade_calc u_grade (
    .crisp   (acc_a),
    .point_1 (desc[0]),
    .slope_1 (desc[1]),
    .point_2 (desc[2]),
    .slope_2 (desc[3]),
    .grade   (grade)
  );

  logic min_sel;
  assign min_sel = (b1 == op_min_to_acc_a) || (b1 == op_min_to_memory);

  always_comb begin
    mem.wr    = 1'b0;
    mem.addr  = src_addr;
    mem.wdata = data_lo;
    if (state == st_wr) begin
      if (is_mem_grade) begin
        mem.wr    = 1'b1;
        mem.addr  = index_y[7:0];
        mem.wdata = grade;
      end else if (is_minmax) begin
        mem.wr   = (b1 == op_max_to_memory) || (b1 == op_min_to_memory);
        mem.addr = dst_addr;
        // borrow means memory is larger
        mem.wdata = (min_sel ^ borrow_q) ? data_lo : acc_a;
      end else begin
        // move writes only the destination
        mem.wr    = 1'b1;
        mem.addr  = dst_addr;
        mem.wdata = is_word ? data_hi : data_lo;
      end
    end else if (state == st_wr2) begin
      mem.wr    = 1'b1;
      mem.addr  = 8'(dst_addr + 8'd1);
      mem.wdata = data_lo;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      borrow_q <= 1'b0;
    end else if (state == st_exec) begin
      borrow_q <= borrow;
    end
  end

  // ----------------------------------------
  // cpu registers and apb
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_a   <= 8'h00;
      index_x <= word_reset;
      index_y <= word_reset;
      cc_bits <= cc_reset;
      instr   <= 32'h0000_0000;
      opnd    <= word_reset;
    end else if (psel && penable && pwrite && state == st_idle) begin
      case (paddr)
        off_acc_a:   acc_a   <= pwdata[7:0];
        off_index_x: index_x <= pwdata[15:0];
        off_index_y: index_y <= pwdata[15:0];
        off_cc:      cc_bits <= pwdata[7:0];
        off_instr:   instr   <= pwdata;
        off_opnd:    opnd    <= pwdata[15:0];
        default: ;
      endcase
    end else if (state == st_exec && is_minmax) begin
      cc_bits[cc_n] <= diff[7];
      cc_bits[cc_z] <= (diff == 8'h00);
      cc_bits[cc_v] <= (acc_a[7] & ~mem.rdata[7] & ~diff[7]) |
                       (~acc_a[7] & mem.rdata[7] & diff[7]);
      cc_bits[cc_c] <= borrow;
      if (b1 == op_max_to_acc_a) begin
        acc_a <= borrow ? mem.rdata : acc_a;
      end else if (b1 == op_min_to_acc_a) begin
        acc_a <= borrow ? acc_a : mem.rdata;
      end
    end else if (state == st_wr && is_mem_grade) begin
      index_y <= 16'(index_y + y_step);
      index_x <= 16'(index_x + x_step);
      cc_bits[cc_h] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      busy    <= 1'b0;
    end else begin
      busy    <= (state != st_idle) || start;
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          off_ctrl:    prdata <= 32'h0000_0000;
          off_status:  prdata <= {29'h0, illegal, done, state != st_idle};
          off_acc_a:   prdata <= {24'h0, acc_a};
          off_index_x: prdata <= {16'h0, index_x};
          off_index_y: prdata <= {16'h0, index_y};
          off_cc:      prdata <= {24'h0, cc_bits};
          off_instr:   prdata <= instr;
          off_opnd:    prdata <= {16'h0, opnd};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
  // moves never touch cc_bits: only the apb write, min/max and membership branches write it
endmodule : minmax_fuzzy_move_exec
`default_nettype wire

// ---- pkg/mem_if.sv ----
// interface: one-port byte memory access between the sequencer and its memory
`timescale 1ns/1ns
`default_nettype none
interface mem_if;
  logic       wr;     // write strobe
  logic [7:0] addr;   // byte address
  logic [7:0] wdata;  // write byte
  logic [7:0] rdata;  // registered read byte
  modport master (output wr, output addr, output wdata, input rdata);
  modport slave  (input wr, input addr, input wdata, output rdata);
endinterface : mem_if
`default_nettype wire

// ---- pkg/minmax_pkg.sv ----
// package: opcodes, register offsets and field positions of the compare/select, membership and move unit
`default_nettype none
package minmax_pkg;
  // prefix byte, membership opcode and second opcode bytes
  localparam logic [7:0] prefix_byte      = 8'h18;
  localparam logic [7:0] op_max_to_acc_a  = 8'h18;
  localparam logic [7:0] op_min_to_acc_a  = 8'h19;
  localparam logic [7:0] op_max_to_memory = 8'h1c;
  localparam logic [7:0] op_min_to_memory = 8'h1d;
  localparam logic [7:0] op_membership    = 8'h01;
  localparam logic [7:0] op_byte_lit_ptr  = 8'h08;
  localparam logic [7:0] op_byte_abs_ptr  = 8'h09;
  localparam logic [7:0] op_byte_ptr_ptr  = 8'h0a;
  localparam logic [7:0] op_byte_lit_abs  = 8'h0b;
  localparam logic [7:0] op_byte_abs_abs  = 8'h0c;
  localparam logic [7:0] op_byte_ptr_abs  = 8'h0d;
  localparam logic [7:0] op_word_lit_ptr  = 8'h00;
  localparam logic [7:0] op_word_abs_ptr  = 8'h01;
  localparam logic [7:0] op_word_ptr_ptr  = 8'h02;
  localparam logic [7:0] op_word_lit_abs  = 8'h03;
  localparam logic [7:0] op_word_abs_abs  = 8'h04;
  localparam logic [7:0] op_word_ptr_abs  = 8'h05;
  // apb register byte offsets
  localparam logic [11:0] off_ctrl   = 12'h000;
  localparam logic [11:0] off_status = 12'h004;
  localparam logic [11:0] off_acc_a  = 12'h008;
  localparam logic [11:0] off_index_x = 12'h00c;
  localparam logic [11:0] off_index_y = 12'h010;
  localparam logic [11:0] off_cc     = 12'h014;
  localparam logic [11:0] off_instr  = 12'h018;
  localparam logic [11:0] off_opnd   = 12'h01c;
  // instruction word fields: [31:24] first, [23:16] second, [15:8] third byte
  localparam int instr_b0_lsb = 24;
  localparam int instr_b1_lsb = 16;
  localparam int instr_b2_lsb = 8;
  // condition code bit positions (s x h i n z v c)
  localparam int cc_c = 0;
  localparam int cc_v = 1;
  localparam int cc_z = 2;
  localparam int cc_n = 3;
  localparam int cc_h = 5;
  // status bits
  localparam int st_busy    = 0;
  localparam int st_done    = 1;
  localparam int st_illegal = 2;
  // reset values and constants
  localparam logic [7:0]  cc_reset = 8'hd0;
  localparam logic [15:0] word_reset = 16'h0000;
  localparam logic [7:0]  grade_full = 8'hff;
  localparam logic [7:0]  slope_infinite = 8'h00;
  localparam logic [15:0] x_step = 16'h0004;
  localparam logic [15:0] y_step = 16'h0001;
  // memory
  localparam int mem_aw = 8;
  localparam int mem_depth = 256;
endpackage : minmax_pkg
`default_nettype wire
